// [shared/sac_defines.svh]
// Register offsets, field positions, reset values and counts of the converter control block
`ifndef SAC_DEFINES_SVH
`define SAC_DEFINES_SVH

// Byte addresses on the register bus
`define SAC_OFS_CTRL0 5'h00
`define SAC_OFS_CTRL1 5'h04
`define SAC_OFS_RESH 5'h08
`define SAC_OFS_RESL 5'h0C
`define SAC_OFS_STATUS 5'h10
`define SAC_OFS_MASK 5'h14

// Control register 0 fields
`define SAC_C0_ON 0
`define SAC_C0_GO 1
`define SAC_C0_CH_LO 2
`define SAC_C0_CH_HI 6
`define SAC_CTRL0_RESET 8'h00

// Control register 1 fields
`define SAC_C1_CS_LO 4
`define SAC_C1_CS_HI 6
`define SAC_CTRL1_RESET 8'h00

// Status and mask fields
`define SAC_ST_DONE 0
`define SAC_MASK_RESET 8'h00

// Conversion clock select codes
`define SAC_CS_DIV8 3'h1
`define SAC_CS_DIV16 3'h5
`define SAC_CS_DIV32 3'h2
`define SAC_CS_DIV64 3'h6

// Divisors, in system clocks or in oscillator edges
`define SAC_DIV8 7'h08
`define SAC_DIV16 7'h10
`define SAC_DIV32 7'h20
`define SAC_DIV64 7'h40
`define SAC_RC_DIV 7'h10

// Bit periods per conversion and result width
`define SAC_TAD_COUNT 4'hB
`define SAC_RES_BITS 10
`define SAC_SYNC_STAGES 2

`endif

// [shared/sac_pkg.sv]
// Types shared by the converter control block
package sac_pkg;

	typedef enum logic [1:0] {
		SAC_IDLE = 2'b00,
		SAC_START = 2'b01,
		SAC_BITS = 2'b10,
		SAC_DONE = 2'b11
	} sac_state_type;

	typedef logic [9:0] sac_result_type;

endpackage

// [hw/sac_clkgen.sv]
// Bit-period tick generator from the divided system clock or the internal oscillator
`timescale 1ns/1ns
`default_nettype none
`include "sac_defines.svh"

module sac_clkgen
	import sac_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic [2:0] sel,
	input wire logic rc_rise,
	output logic tad_tick
);

	logic [6:0] cnt;
	logic [6:0] div;
	logic use_rc;
	logic step;

	// Divisor decode; codes ending in 11 pick the oscillator
	function automatic logic [6:0] sac_div_of(input logic [2:0] s);
		logic [6:0] d;
		d = `SAC_DIV8;
		if (s[1:0] == 2'h3) begin
			d = `SAC_RC_DIV;
		end else if (s == `SAC_CS_DIV16) begin
			d = `SAC_DIV16;
		end else if (s == `SAC_CS_DIV32) begin
			d = `SAC_DIV32;
		end else if (s == `SAC_CS_DIV64) begin
			d = `SAC_DIV64;
		end
		return d;
	endfunction

	assign div = sac_div_of(sel);
	assign use_rc = (sel[1:0] == 2'h3);
	// Oscillator path counts its edges and ignores the system rate
	assign step = use_rc ? rc_rise : 1'b1;

	// Counter restarts whenever no conversion runs, so every period is whole
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 7'h00;
			tad_tick <= 1'b0;
		end else if (!run) begin
			cnt <= 7'h00;
			tad_tick <= 1'b0;
		end else if (step && (cnt == div - 7'h01)) begin
			cnt <= 7'h00;
			tad_tick <= 1'b1;
		end else begin
			cnt <= step ? cnt + 7'h01 : cnt;
			tad_tick <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// [hw/sac_adc.sv]
// Successive-approximation converter control with Avalon-MM registers
// How it works
// - Ten-bit successive approximation, right-justified result pair
// - All channels share one sample-and-hold stage
// - Five-bit channel field in control register zero
// - All thirty-two channel codes pass through
// - Five conversion clock sources, divided or oscillator
// - Oscillator option divides internal oscillator by sixteen
// - One period per bit, eleven per conversion
// - Divided sources track the system clock rate
// - Band gap always supplies the converter reference
// - Enable bit, then go bit starts a conversion
// - Completion clears go, sets flag, loads result
// - Done flag always set, cleared only by software
//
// Decided for this implementation: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "sac_defines.svh"

module sac_adc
	import sac_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic [4:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	output logic IRQ,
	input wire logic RC_OSC,
	input wire logic CMP_IN,
	output logic [4:0] CH_SEL,
	output logic SH_HOLD,
	output logic [9:0] DAC_CODE,
	output logic REF_BG_SEL,
	output logic BUSY
);

	localparam int SYNC_BITS = 2;
	// Reset image of control register zero, so single bits can be picked from it
	localparam logic [7:0] CTRL0_RST = `SAC_CTRL0_RESET;

	sac_state_type state;
	logic ack;
	logic req;
	logic wr_en;
	logic on_bit;
	logic go_bit;
	logic [4:0] channel_select_field;
	logic [2:0] conv_clock_select;
	sac_result_type result;
	sac_result_type trial;
	logic [3:0] bit_idx;
	logic done_flag;
	logic done_mask;
	logic tad_tick;
	logic run;
	logic rc_prev;
	logic conv_done;
	logic go_set;
	logic go_clear_sw;
	logic [SYNC_BITS-1:0] sync_in;
	logic [SYNC_BITS-1:0] sync_s1;
	logic [SYNC_BITS-1:0] sync_s2;
	logic cmp_s;
	logic rc_s;

	// Address decode shared by the read and write paths
	function automatic logic [2:0] sac_decode(input logic [4:0] a);
		logic [2:0] r;
		r = 3'h7;
		if (a == `SAC_OFS_CTRL0) begin
			r = 3'h0;
		end else if (a == `SAC_OFS_CTRL1) begin
			r = 3'h1;
		end else if (a == `SAC_OFS_RESH) begin
			r = 3'h2;
		end else if (a == `SAC_OFS_RESL) begin
			r = 3'h3;
		end else if (a == `SAC_OFS_STATUS) begin
			r = 3'h4;
		end else if (a == `SAC_OFS_MASK) begin
			r = 3'h5;
		end
		return r;
	endfunction

	// Two-stage synchronisers for the comparator and oscillator pins
	assign sync_in = {RC_OSC, CMP_IN};
	genvar gi;
	generate
		for (gi = 0; gi < SYNC_BITS; gi++) begin : g_sync
			always_ff @(posedge CLK or negedge RST_N) begin
				if (!RST_N) begin
					sync_s1[gi] <= 1'b0;
					sync_s2[gi] <= 1'b0;
				end else begin
					sync_s1[gi] <= sync_in[gi];
					sync_s2[gi] <= sync_s1[gi];
				end
			end
		end
	endgenerate
	assign cmp_s = sync_s2[0];
	assign rc_s = sync_s2[1];

	// Oscillator edge detect works on the settled stage only
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rc_prev <= 1'b0;
		end else begin
			rc_prev <= rc_s;
		end
	end

	assign run = (state != SAC_IDLE);

	sac_clkgen u_clkgen (
		.clk(CLK),
		.rst_n(RST_N),
		.run(run),
		.sel(conv_clock_select),
		.rc_rise(rc_s & ~rc_prev),
		.tad_tick(tad_tick)
	);

	// One wait state per access; read data is registered before the release
	assign req = AVS_READ | AVS_WRITE;
	assign AVS_WAITREQUEST = req & ~ack;
	assign wr_en = AVS_WRITE & ack & AVS_BYTEENABLE[0];

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ack <= 1'b0;
		end else begin
			ack <= req & ~ack;
		end
	end

	// Read mux; unmapped offsets and upper bits read as zero
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			AVS_READDATA <= 32'h0000_0000;
		end else if (AVS_READ && !ack) begin
			case (sac_decode(AVS_ADDRESS))
				3'h0: AVS_READDATA <= {25'h0, channel_select_field, go_bit, on_bit};
				3'h1: AVS_READDATA <= {25'h0, conv_clock_select, 4'h0};
				3'h2: AVS_READDATA <= {30'h0, result[9:8]};
				3'h3: AVS_READDATA <= {24'h0, result[7:0]};
				3'h4: AVS_READDATA <= {31'h0, done_flag};
				3'h5: AVS_READDATA <= {31'h0, done_mask};
				default: AVS_READDATA <= 32'h0000_0000;
			endcase
		end
	end

	// Configuration fields written by software
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			on_bit <= CTRL0_RST[`SAC_C0_ON];
			channel_select_field <= 5'h00;
			conv_clock_select <= 3'h0;
			done_mask <= 1'b0;
		end else if (wr_en) begin
			if (sac_decode(AVS_ADDRESS) == 3'h0) begin
				on_bit <= AVS_WRITEDATA[`SAC_C0_ON];
				// Any of the 32 codes passes; reserved ones select nothing useful
				channel_select_field <= AVS_WRITEDATA[`SAC_C0_CH_HI:`SAC_C0_CH_LO];
			end else if (sac_decode(AVS_ADDRESS) == 3'h1) begin
				conv_clock_select <= AVS_WRITEDATA[`SAC_C1_CS_HI:`SAC_C1_CS_LO];
			end else if (sac_decode(AVS_ADDRESS) == 3'h5) begin
				done_mask <= AVS_WRITEDATA[`SAC_ST_DONE];
			end
		end
	end

	// Go only counts when the converter was already on before this write
	assign go_set = wr_en && (sac_decode(AVS_ADDRESS) == 3'h0) &&
		AVS_WRITEDATA[`SAC_C0_GO] && AVS_WRITEDATA[`SAC_C0_ON] && on_bit;
	assign go_clear_sw = wr_en && (sac_decode(AVS_ADDRESS) == 3'h0) &&
		(!AVS_WRITEDATA[`SAC_C0_GO] || !AVS_WRITEDATA[`SAC_C0_ON]);
	assign conv_done = (state == SAC_DONE);

	// Go bit: software start, hardware clear at completion, software abort
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			go_bit <= 1'b0;
		end else if (go_set && state == SAC_IDLE) begin
			go_bit <= 1'b1;
		end else if (conv_done || go_clear_sw) begin
			go_bit <= 1'b0;
		end
	end

	// Conversion sequence: one start period, then ten bit periods
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state <= SAC_IDLE;
			bit_idx <= 4'h0;
			trial <= 10'h000;
		end else begin
			case (state)
				SAC_IDLE: begin
					if (go_bit && on_bit) begin
						state <= SAC_START;
						trial <= 10'h000;
					end
				end
				SAC_START: begin
					if (!go_bit || !on_bit) begin
						state <= SAC_IDLE;
					end else if (tad_tick) begin
						state <= SAC_BITS;
						bit_idx <= 4'(`SAC_RES_BITS - 1);
						trial <= 10'h200;
					end
				end
				SAC_BITS: begin
					if (!go_bit || !on_bit) begin
						state <= SAC_IDLE; // Abort leaves the old result untouched
					end else if (tad_tick) begin
						// Keep the trial bit while the held level is at or above it
						if (!cmp_s) begin
							trial[bit_idx] <= 1'b0;
						end
						if (bit_idx == 4'h0) begin
							state <= SAC_DONE;
						end else begin
							trial[bit_idx - 4'h1] <= 1'b1;
							bit_idx <= bit_idx - 4'h1;
						end
					end
				end
				SAC_DONE: begin
					state <= SAC_IDLE;
				end
				default: begin
					state <= SAC_IDLE;
				end
			endcase
		end
	end

	// Result pair loads in the single completion cycle only
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			result <= 10'h000;
		end else if (conv_done) begin
			result <= trial;
		end
	end

	// Done flag is sticky; a completion wins over a same-cycle clear
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			done_flag <= 1'b0;
		end else if (conv_done) begin
			done_flag <= 1'b1;
		end else if (wr_en && sac_decode(AVS_ADDRESS) == 3'h4 &&
			AVS_WRITEDATA[`SAC_ST_DONE]) begin
			done_flag <= 1'b0;
		end
	end

	// Analog side drive: one mux select, hold during bit periods
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			CH_SEL <= 5'h00;
			SH_HOLD <= 1'b0;
			DAC_CODE <= 10'h000;
			BUSY <= 1'b0;
			IRQ <= 1'b0;
		end else begin
			// Mux follows the field one clock later; settling time is software's wait
			CH_SEL <= channel_select_field;
			SH_HOLD <= (state == SAC_BITS) || (state == SAC_START && tad_tick);
			DAC_CODE <= trial;
			BUSY <= run;
			IRQ <= done_flag & done_mask;
		end
	end

	// Reference is fixed to the band gap; no other source exists here
	assign REF_BG_SEL = 1'b1;

endmodule
`default_nettype wire

// [sim/sac_adc_checker.sv]
// Port checks for the converter control block
`timescale 1ns/1ns
`default_nettype none
`include "sac_defines.svh"
module sac_adc_checker(
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic [4:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	input wire logic [31:0] AVS_READDATA,
	input wire logic AVS_WAITREQUEST,
	input wire logic [4:0] CH_SEL,
	input wire logic SH_HOLD,
	input wire logic [9:0] DAC_CODE,
	input wire logic REF_BG_SEL,
	input wire logic BUSY
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	logic rd_ok;
	logic [4:0] wr_ch;
	// Read answer cycle
	assign rd_ok = AVS_READ && !AVS_WAITREQUEST;
	// Channel field as it stands on the write data
	assign wr_ch = AVS_WRITEDATA[`SAC_C0_CH_HI:`SAC_C0_CH_LO];
	chk_ref_bandgap: assert property (REF_BG_SEL)
		else $error("reference not band gap");
	chk_hold_busy: assert property (SH_HOLD |-> BUSY)
		else $error("hold outside conversion");
	// The trial code reaches its pin one cycle after the hold goes up
	chk_dac_first: assert property ($rose(SH_HOLD) |-> ##1 DAC_CODE == 10'h200)
		else $error("first trial code wrong");
	chk_hold_min: assert property ($rose(SH_HOLD) |-> SH_HOLD[*8])
		else $error("bit period too short");
	// Field stores at the accepting edge, the mux select one edge later
	chk_channel_copy: assert property (
		AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0] && AVS_ADDRESS == `SAC_OFS_CTRL0
		|-> ##2 CH_SEL == $past(wr_ch, 2)) else $error("channel not applied");
	chk_unmapped_zero: assert property (rd_ok && AVS_ADDRESS >= 5'h18 |-> AVS_READDATA == 32'h0)
		else $error("unmapped read not zero");
	chk_resh_upper: assert property (rd_ok && AVS_ADDRESS == `SAC_OFS_RESH |->
		AVS_READDATA[31:2] == 30'h0) else $error("result high not justified");
	chk_wait_one: assert property ($rose(AVS_READ || AVS_WRITE) |->
		AVS_WAITREQUEST ##1 !AVS_WAITREQUEST) else $error("wait cycle count wrong");
endmodule
bind sac_adc sac_adc_checker chk_u(.CLK(CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS),
	.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
	.AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
	.AVS_WAITREQUEST(AVS_WAITREQUEST), .CH_SEL(CH_SEL), .SH_HOLD(SH_HOLD),
	.DAC_CODE(DAC_CODE), .REF_BG_SEL(REF_BG_SEL), .BUSY(BUSY));
`default_nettype wire

// [sim/sac_analog_model.sv]
// Analog channel mux, hold capacitor and comparator model
`timescale 1ns/1ns
`default_nettype none
module sac_analog_model(
	input wire logic [4:0] ch_sel,
	input wire logic sh_hold,
	input wire logic [9:0] dac_code,
	output logic cmp_in
);
	// Every channel here is a pure analog input, so no pin setup is modelled
	logic [9:0] held = 10'h000;
	// Level tracks the channel while sampling, frozen while held
	always @(ch_sel or sh_hold) if (!sh_hold) held = {ch_sel, ch_sel};
	// High while held level reaches the trial code
	assign cmp_in = (held >= dac_code);
endmodule
`default_nettype wire

// [sim/sac_adc_tb.sv]
// Self-checking bench for the converter control block
`timescale 1ns/1ns
`default_nettype none
`include "sac_defines.svh"
module sac_adc_tb
	import sac_pkg::*;
;
	logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, rc = 1'b0;
	logic [4:0] addr = 5'h00;
	logic [31:0] wdata = 32'h0, rdata, last;
	logic [3:0] be = 4'hF;
	logic wreq, irq, cmp, hold, refbg, busy;
	logic [4:0] ch;
	logic [9:0] dac;
	logic [31:0] expq[$];
	sac_result_type last_r;
	int failures = 0, total_checks = 0, bcnt = 0;
	sac_adc dut_u(.CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
		.AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
		.AVS_WAITREQUEST(wreq), .IRQ(irq), .RC_OSC(rc), .CMP_IN(cmp), .CH_SEL(ch),
		.SH_HOLD(hold), .DAC_CODE(dac), .REF_BG_SEL(refbg), .BUSY(busy));
	sac_analog_model ana_u(.ch_sel(ch), .sh_hold(hold), .dac_code(dac), .cmp_in(cmp));
	// System clock, and an oscillator of unrelated phase: 16 edges take 72 cycles
	initial forever #20 clk = ~clk;
	// Offset keeps oscillator edges off both clock edges
	initial begin
		#5;
		forever #90 rc = ~rc;
	end
	// Busy cycle count, for the conversion length
	always @(posedge clk) if (busy === 1'b1) bcnt <= bcnt + 1;
	// Read answers compared against the oldest expectation at the accepting edge
	always @(posedge clk) if (rd === 1'b1 && wreq === 1'b0 && expq.size() > 0) begin
		chk(rdata, expq.pop_front());
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One bus access; a free edge first so strobes never change twice in a step
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		// Waitrequest and read data are taken at the same rising edge
		do begin
			@(posedge clk);
			n++;
		end while (wreq !== 1'b0 && n < 20);
		last = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
		if (n >= 20) failures++;
	endtask
	task automatic wr8(input logic [4:0] a, input logic [7:0] d);
		bus(1'b1, a, {24'h0, d});
	endtask
	task automatic rdx(input logic [4:0] a, input logic [31:0] e);
		expq.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask
	// One conversion; the source is chosen so the period is long enough
	task automatic conv(input logic [2:0] cs, input int t, input logic [4:0] c, input logic m);
		int b0, n, d;
		n = 0;
		last_r = {c, c};
		wr8(`SAC_OFS_MASK, {7'h0, m});
		wr8(`SAC_OFS_CTRL1, {1'b0, cs, 4'h0});
		wr8(`SAC_OFS_CTRL0, {1'b0, c, 2'b01});
		repeat (20) @(posedge clk); // Acquisition delay after a channel change
		b0 = bcnt;
		wr8(`SAC_OFS_CTRL0, {1'b0, c, 2'b11});
		do begin
			bus(1'b0, `SAC_OFS_CTRL0, 32'h0);
			n++;
		end while (last[1] !== 1'b0 && n < 2000);
		if (n >= 2000) failures++;
		repeat (4) @(posedge clk);
		d = bcnt - b0;
		chk({31'h0, d >= 11 * t - 8 && d <= 11 * t + 8}, 32'h1);
		rdx(`SAC_OFS_RESH, {30'h0, last_r[9:8]});
		rdx(`SAC_OFS_RESL, {24'h0, last_r[7:0]});
		rdx(`SAC_OFS_STATUS, 32'h1);
		chk({31'h0, irq}, {31'h0, m});
		wr8(`SAC_OFS_STATUS, 8'h01);
		rdx(`SAC_OFS_STATUS, 32'h0);
		chk({31'h0, irq}, 32'h0);
	endtask
	task automatic tally_and_finish;
		if (failures == 0 && total_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// Watchdog, well past the longest expected run
	initial begin
		#2000000;
		failures++;
		tally_and_finish;
	end
	// Main sequence
	initial begin
		static logic [2:0] cs[5] = '{`SAC_CS_DIV8, `SAC_CS_DIV16, `SAC_CS_DIV32, `SAC_CS_DIV64, 3'h3};
		static int tv[5] = '{8, 16, 32, 64, 72};
		void'($urandom(26189));
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		for (int a = 0; a < 7; a++) rdx(5'(a * 4), 32'h0);
		be <= 4'h0;
		wr8(`SAC_OFS_MASK, 8'h01);
		be <= 4'hF;
		rdx(`SAC_OFS_MASK, 32'h0);
		wr8(`SAC_OFS_CTRL0, 8'h03); // Refused: go with enable from off
		rdx(`SAC_OFS_CTRL0, 32'h1);
		for (int i = 0; i < 5; i++) conv(cs[i], tv[i], 5'($urandom), i[0]);
		// Abort mid conversion: result and flag stay
		wr8(`SAC_OFS_CTRL1, 8'h60);
		wr8(`SAC_OFS_CTRL0, 8'h7F);
		repeat (100) @(posedge clk);
		wr8(`SAC_OFS_CTRL0, 8'h7D);
		repeat (4) @(posedge clk);
		chk({31'h0, busy}, 32'h0);
		rdx(`SAC_OFS_RESL, {24'h0, last_r[7:0]});
		rdx(`SAC_OFS_STATUS, 32'h0);
		tally_and_finish;
	end
endmodule
`default_nettype wire
